/* File: src/reload_timer_control.sv */
// reload_timer_control: registers, event flags and interrupts of four reload timers
// assumes capture, compare and pwm datapaths sit outside on mclk and report hits here
// How it works
// - pwm and capture/compare never flag together
// - capture and compare flags set independently
// - break-stop bit holds count during debug break
// - source field picks prescaler, rtc or edge
// - divider field picks prescale 4/16/64/256
// - single pass clears run at end
// - continuous mode reloads at end, keeps counting
// - writing force-reload one loads reload value
// - run bit starts and stops the counter
// - compare enables act only in compare mode
// - only implemented enable bits take effect
// - enable bit zero gates end-of-count interrupt
// - enable bits one, two gate captures, trip
// - reading event flags clears them
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module reload_timer_control
	import timer_pkg::*;
(
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]       address,
	input  wire logic                    read,
	input  wire logic                    write,
	input  wire logic [DATA_W-1:0]       writedata,
	input  wire logic [3:0]              byteenable,
	output logic      [DATA_W-1:0]       readdata,
	output logic                         waitrequest,
	// pins
	input  wire logic                    rtc_clock,
	input  wire logic [NUM_TIMERS-1:0]   event_count_pin,
	// debug and datapath status
	input  wire logic                    debug_break,
	input  wire logic                    pwm_active,
	input  wire logic                    compare_mode,
	input  wire logic [NUM_TIMERS-1:0]   capture_a_hit,
	input  wire logic [NUM_TIMERS-1:0]   capture_b_hit,
	input  wire logic                    trip_hit,
	input  wire logic [3:0]              compare_hit,
	// outputs
	output logic [NUM_TIMERS*COUNT_W-1:0] timer_count,
	output logic [NUM_TIMERS-1:0]        timer_irq,
	output logic                         irq
);
	logic [7:0]          word_idx;
	logic                ack;
	logic                wr_acc;
	logic                rd_acc;
	logic [7:0]          rd_mux;
	logic                rtc_meta;
	logic                rtc_sync;
	logic                rtc_prev;
	logic [NUM_TIMERS-1:0] ec_meta;
	logic [NUM_TIMERS-1:0] ec_sync;
	logic [NUM_TIMERS-1:0] ec_prev;
	logic                rtc_rise;
	logic [NUM_TIMERS-1:0] ec_rise;
	logic [NUM_TIMERS-1:0] ec_fall;
	logic [7:0]          control [NUM_TIMERS];
	logic [7:0]          ier     [NUM_TIMERS];
	logic [7:0]          flags   [NUM_TIMERS];
	logic [7:0]          new_ev  [NUM_TIMERS];
	logic [7:0]          eff_ier [NUM_TIMERS];
	logic [COUNT_W-1:0]  reload  [NUM_TIMERS];
	logic [COUNT_W-1:0]  count   [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] wr_ctl;
	logic [NUM_TIMERS-1:0] wr_ier;
	logic [NUM_TIMERS-1:0] rd_flg;
	logic [NUM_TIMERS-1:0] end_hit;
	logic [NUM_TIMERS-1:0] halt;
	logic [NUM_TIMERS-1:0] irq_set;
	logic [NUM_TIMERS-1:0] irq_status;
	logic [NUM_TIMERS-1:0] irq_mask;
	logic                cap_ok;
	logic                cmp_ok;

	// bus slave: one wait cycle, read data registered during it
	assign word_idx    = address[9:2];
	assign waitrequest = (read || write) && !ack;
	assign wr_acc      = write && ack && byteenable[0];
	assign rd_acc      = read && ack;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ack <= 1'b0;
		end else begin
			ack <= (read || write) && !ack;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (word_idx == CONTROL_IDX[i]) begin
				rd_mux = control[i];
			end
			if (word_idx == IER_IDX[i]) begin
				rd_mux = ier[i];
			end
			if (word_idx == FLAGS_IDX[i]) begin
				rd_mux = flags[i];
			end
			if (word_idx == COUNT_LO_IDX[i]) begin
				rd_mux = count[i][7:0];
			end
			if (word_idx == COUNT_HI_IDX[i]) begin
				rd_mux = count[i][15:8];
			end
		end
		if (word_idx == IRQ_STATUS_IDX) begin
			rd_mux = {4'h0, irq_status};
		end
		if (word_idx == IRQ_MASK_IDX) begin
			rd_mux = {4'h0, irq_mask};
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= '0;
		end else if (read && !ack) begin
			readdata <= {24'h000000, rd_mux};
		end
	end

	// pin synchronisers and edge detect on the settled copy
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rtc_meta <= 1'b0;
			rtc_sync <= 1'b0;
			rtc_prev <= 1'b0;
			ec_meta  <= '0;
			ec_sync  <= '0;
			ec_prev  <= '0;
		end else begin
			rtc_meta <= rtc_clock;
			rtc_sync <= rtc_meta;
			rtc_prev <= rtc_sync;
			ec_meta  <= event_count_pin;
			ec_sync  <= ec_meta;
			ec_prev  <= ec_sync;
		end
	end

	assign rtc_rise = rtc_sync && !rtc_prev;
	assign ec_rise  = ec_sync & ~ec_prev;
	assign ec_fall  = ~ec_sync & ec_prev;

	// pwm owns the shared register range, so capture/compare hits are dropped then
	assign cap_ok = !pwm_active;
	assign cmp_ok = !pwm_active && compare_mode;

	for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
		assign wr_ctl[i] = wr_acc && (word_idx == CONTROL_IDX[i]);
		assign wr_ier[i] = wr_acc && (word_idx == IER_IDX[i]);
		assign rd_flg[i] = rd_acc && (word_idx == FLAGS_IDX[i]);
		assign halt[i]   = control[i][HALT_BIT] && debug_break;

		// capture and compare land in separate flag bits
		assign new_ev[i] = IMPL_MASK[i] & {1'b0,
			compare_hit & {4{cmp_ok}},
			capture_b_hit[i] && cap_ok,
			pwm_active ? (trip_hit && i == TRIP_TIMER) : capture_a_hit[i],
			end_hit[i]};

		assign eff_ier[i] = ier[i] & (compare_mode ? 8'hff : ~CMP_MASK);
		assign timer_irq[i] = |(flags[i] & eff_ier[i]);
		assign irq_set[i]   = |(new_ev[i] & eff_ier[i]);
		assign timer_count[i*COUNT_W +: COUNT_W] = count[i];

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				control[i] <= CONTROL_RESET;
			end else if (wr_ctl[i]) begin
				control[i] <= {writedata[7:2], 1'b0, writedata[RUN_BIT]};
			end else if (end_hit[i] && !control[i][CONT_BIT]) begin
				control[i][RUN_BIT] <= 1'b0;
			end
		end

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				ier[i] <= IER_RESET;
			end else if (wr_ier[i]) begin
				ier[i] <= writedata[7:0] & IMPL_MASK[i];
			end
		end

		// only the bits handed out by the read are cleared; a new event wins
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				flags[i] <= FLAGS_RESET;
			end else begin
				flags[i] <= (flags[i] & ~(rd_flg[i] ? readdata[7:0] : 8'h00))
					| new_ev[i];
			end
		end

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				reload[i] <= RELOAD_RESET;
			end else if (wr_acc && word_idx == COUNT_LO_IDX[i]) begin
				reload[i][7:0] <= writedata[7:0];
			end else if (wr_acc && word_idx == COUNT_HI_IDX[i]) begin
				reload[i][15:8] <= writedata[7:0];
			end
		end

		reload_timer_core #(
			.CNT_W (COUNT_W),
			.PRE_W (8)
		) u_core (
			.mclk       (mclk),
			.reset_n    (reset_n),
			.run        (control[i][RUN_BIT]),
			.halt       (halt[i]),
			.continuous (control[i][CONT_BIT]),
			.source     (control[i][SRC_LSB +: 2]),
			.divider    (control[i][DIV_LSB +: 2]),
			.load_now   (wr_ctl[i] && writedata[RELOAD_BIT]),
			.reload     (reload[i]),
			.rtc_rise   (rtc_rise),
			.ec_fall    (ec_fall[i]),
			.ec_rise    (ec_rise[i]),
			.count      (count[i]),
			.end_hit    (end_hit[i])
		);
	end

	// summary interrupt: sticky per-timer status, write one to clear, set wins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= IRQ_RESET;
		end else begin
			irq_status <= (irq_status
				& ~((wr_acc && word_idx == IRQ_STATUS_IDX) ? writedata[3:0] : 4'h0))
				| irq_set;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask <= IRQ_RESET;
		end else if (wr_acc && word_idx == IRQ_MASK_IDX) begin
			irq_mask <= writedata[3:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence s_quiet0;
		!wr_ctl[0] && !halt[0];
	endsequence

	sequence s_div4_run0;
		(control[0][RUN_BIT] && control[0][SRC_LSB +: 2] == SRC_PRESCALE
			&& control[0][DIV_LSB +: 2] == 2'h0) and s_quiet0;
	endsequence

	AST_FORCE_LOAD: assert property (
		wr_ctl[0] && writedata[RELOAD_BIT] |=> count[0] == $past(reload[0]))
		else $error("force reload did not load the counter");

	AST_SINGLE_STOP: assert property (
		end_hit[0] && !control[0][CONT_BIT] && !wr_ctl[0]
		|=> !control[0][RUN_BIT] && count[0] == 16'h0000
			##1 ($stable(count[0]) || $past(wr_ctl[0])))
		else $error("single pass did not stop at end of count");

	AST_CONT_RELOAD: assert property (
		end_hit[0] && control[0][CONT_BIT] && !wr_ctl[0]
		|=> control[0][RUN_BIT] && count[0] == $past(reload[0]))
		else $error("continuous mode did not reload");

	AST_HALT_HOLD: assert property (
		halt[0] && !wr_ctl[0] |=> $stable(count[0]))
		else $error("counter moved during debug break");

	AST_RUN_OFF: assert property (
		!control[0][RUN_BIT] && !wr_ctl[0] |=> $stable(count[0]))
		else $error("disabled timer changed its count");

	AST_DIV4_SPACING: assert property (
		s_div4_run0 ##1 (s_div4_run0 and $changed(count[0]))
		|=> (!$changed(count[0]) || !control[0][RUN_BIT] || $past(wr_ctl[0]))[*3])
		else $error("divide by four stepped too early");

	AST_EC_RISE_STEP: assert property (
		(control[0][RUN_BIT] && control[0][SRC_LSB +: 2] == SRC_EC_RISE
		&& count[0] > 16'h0001) and s_quiet0
		|-> (ec_rise[0] ##1 count[0] == $past(count[0]) - 16'h0001)
			or (!ec_rise[0] ##1 $stable(count[0])))
		else $error("event count source stepped wrongly");

	AST_FLAG_CLEAR: assert property (
		rd_flg[0] && new_ev[0] == 8'h00 && flags[0] == readdata[7:0] |=> flags[0] == 8'h00)
		else $error("event flags not cleared by read");

	AST_EOC_IRQ: assert property (
		end_hit[0] && ier[0][EOC_BIT] |=> timer_irq[0] && irq_status[0])
		else $error("end of count did not raise an interrupt");

	AST_EOC_MASKED: assert property (
		!ier[0][EOC_BIT] |-> !timer_irq[0])
		else $error("masked end of count raised an interrupt");

	AST_IER_IMPL: assert property (
		wr_ier[0] |=> ier[0][7:1] == 7'h00 && ier[2][7:1] == 7'h00)
		else $error("unimplemented enable bit took a value");

	AST_CMP_GATED: assert property (
		!compare_mode && (flags[3] & ier[3] & 8'h07) == 8'h00 |-> !timer_irq[3])
		else $error("compare interrupt outside compare mode");

	AST_PWM_EXCL: assert property (
		pwm_active && !trip_hit && !flags[3][CAPA_BIT] |=> !flags[3][CAPA_BIT])
		else $error("capture flagged while pwm owns the timer");

	AST_CAP_CMP: assert property (
		cmp_ok && capture_a_hit[3] && compare_hit[0] |=> flags[3][CAPA_BIT] && flags[3][CMP_LSB])
		else $error("capture and compare did not both flag");

	AST_CAPB_IRQ: assert property (
		cap_ok && capture_b_hit[1] && ier[1][CAPB_BIT] && !wr_ier[1]
		|=> timer_irq[1] && irq_status[1])
		else $error("capture b did not raise an interrupt");

	AST_IRQ_OUT: assert property (
		irq_set[0] && irq_mask[0] && !wr_acc |=> irq ##1 (irq || $past(wr_acc)))
		else $error("summary interrupt not raised");
endmodule // reload_timer_control

/* File: src/timer_pkg.sv */
// timer_pkg: register indices, field layout, reset values and clock source codes
// of the four reload timers; assumes each byte register takes one 32-bit word
package timer_pkg;
	localparam int NUM_TIMERS = 4;
	localparam int COUNT_W    = 16;
	localparam int ADDR_W     = 10;
	localparam int DATA_W     = 32;

	// register indices, entry i belongs to timer i; byte address is four times the index
	localparam logic [3:0][7:0] CONTROL_IDX  = {8'h74, 8'h6f, 8'h65, 8'h60};
	localparam logic [3:0][7:0] IER_IDX      = {8'h75, 8'h70, 8'h66, 8'h61};
	localparam logic [3:0][7:0] FLAGS_IDX    = {8'h76, 8'h71, 8'h67, 8'h62};
	localparam logic [3:0][7:0] COUNT_LO_IDX = {8'h77, 8'h72, 8'h68, 8'h63};
	localparam logic [3:0][7:0] COUNT_HI_IDX = {8'h78, 8'h73, 8'h69, 8'h64};
	localparam logic [7:0]      IRQ_STATUS_IDX = 8'h7a;
	localparam logic [7:0]      IRQ_MASK_IDX   = 8'h7b;

	// control register fields
	localparam int HALT_BIT   = 7;
	localparam int SRC_LSB    = 5;
	localparam int DIV_LSB    = 3;
	localparam int CONT_BIT   = 2;
	localparam int RELOAD_BIT = 1;
	localparam int RUN_BIT    = 0;

	// interrupt enable and event flag fields
	localparam int EOC_BIT  = 0;
	localparam int CAPA_BIT = 1;
	localparam int CAPB_BIT = 2;
	localparam int CMP_LSB  = 3;
	localparam logic [7:0] CMP_MASK = 8'h78;

	// clock source codes
	localparam logic [1:0] SRC_PRESCALE = 2'h0;
	localparam logic [1:0] SRC_RTC      = 2'h1;
	localparam logic [1:0] SRC_EC_FALL  = 2'h2;
	localparam logic [1:0] SRC_EC_RISE  = 2'h3;

	// prescaler masks for divide by 4, 16, 64, 256
	localparam logic [3:0][7:0] DIV_MASK = {8'hff, 8'h3f, 8'h0f, 8'h03};

	// enable bits that exist in each timer
	localparam logic [3:0][7:0] IMPL_MASK = {8'h7f, 8'h01, 8'h07, 8'h01};
	localparam int TRIP_TIMER = 3;

	// reset values
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  IER_RESET     = 8'h00;
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [15:0] RELOAD_RESET  = 16'h0000;
	localparam logic [3:0]  IRQ_RESET     = 4'h0;
endpackage

/* File: src/reload_timer_core.sv */
// reload_timer_core: one down-counter with prescaler and clock source select
// assumes count source pulses are already synchronised to mclk
`timescale 1ns/10ps
module reload_timer_core
	import timer_pkg::*;
#(
	parameter int CNT_W = 16,
	parameter int PRE_W = 8
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             reset_n,
	// control
	input  wire logic             run,
	input  wire logic             halt,
	input  wire logic             continuous,
	input  wire logic [1:0]       source,
	input  wire logic [1:0]       divider,
	input  wire logic             load_now,
	input  wire logic [CNT_W-1:0] reload,
	// count sources
	input  wire logic             rtc_rise,
	input  wire logic             ec_fall,
	input  wire logic             ec_rise,
	// status
	output logic      [CNT_W-1:0] count,
	output logic                  end_hit
);
	logic [PRE_W-1:0] prescale;
	logic [PRE_W-1:0] pre_mask;
	logic             pre_tick;
	logic             tick;
	logic             step;

	assign pre_mask = PRE_W'(DIV_MASK[divider]);
	assign pre_tick = (prescale & pre_mask) == pre_mask;

	always_comb begin
		unique case (source)
			SRC_PRESCALE: tick = pre_tick;
			SRC_RTC:      tick = rtc_rise;
			SRC_EC_FALL:  tick = ec_fall;
			SRC_EC_RISE:  tick = ec_rise;
		endcase
	end

	assign step    = run && !halt && tick;
	assign end_hit = step && (count <= CNT_W'(1));

	// prescaler restarts whenever the timer is off, freezes while held
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prescale <= '0;
		end else if (!run) begin
			prescale <= '0;
		end else if (!halt) begin
			prescale <= prescale + PRE_W'(1);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (load_now) begin
			count <= reload;
		end else if (end_hit) begin
			count <= continuous ? reload : '0;
		end else if (step) begin
			count <= count - CNT_W'(1);
		end
	end
endmodule // reload_timer_core

/* File: verif/tb_top.sv */
// tb_top: self-checking bench for reload_timer_control, random stimulus with fixed seed
// assumes one mclk domain and the one-wait-cycle avalon slave described by the designer
`timescale 1ns/10ps
module tb_top;
	import timer_pkg::*;
	logic                         mclk;
	logic                         reset_n;
	logic [ADDR_W-1:0]            address;
	logic                         read;
	logic                         write;
	logic [DATA_W-1:0]            writedata;
	logic [3:0]                   byteenable;
	logic [DATA_W-1:0]            readdata;
	logic                         waitrequest;
	logic                         rtc_clock;
	logic [NUM_TIMERS-1:0]        event_count_pin;
	logic                         debug_break;
	logic                         pwm_active;
	logic                         compare_mode;
	logic [NUM_TIMERS-1:0]        capture_a_hit;
	logic [NUM_TIMERS-1:0]        capture_b_hit;
	logic                         trip_hit;
	logic [3:0]                   compare_hit;
	logic [NUM_TIMERS*COUNT_W-1:0] timer_count;
	logic [NUM_TIMERS-1:0]        timer_irq;
	logic                         irq;
	int                           miscompares;
	int                           n_checks;
	logic [31:0]                  q;
	logic [7:0]                   v;
	int                           n;
	logic                         seen;

	reload_timer_control DUT (.mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .rtc_clock(rtc_clock), .event_count_pin(event_count_pin),
		.debug_break(debug_break), .pwm_active(pwm_active), .compare_mode(compare_mode),
		.capture_a_hit(capture_a_hit), .capture_b_hit(capture_b_hit), .trip_hit(trip_hit),
		.compare_hit(compare_hit), .timer_count(timer_count), .timer_irq(timer_irq), .irq(irq));

	always #2 mclk = ~mclk;

	function automatic logic [15:0] cnt(input int t);
		return timer_count[16*t +: 16];
	endfunction
	function automatic int period(input int d);
		return 4 << (2 * d);
	endfunction

	task automatic complete_run();
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// one avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		address <= {i, 2'b00};
		read <= !w;
		write <= w;
		writedata <= {24'h0, d};
		@(posedge mclk);
		chk(waitrequest, 1'b1);
		while (waitrequest !== 1'b0) begin
			@(posedge mclk);
			k++;
			if (k >= 100) begin
				miscompares++;
				complete_run();
			end
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask
	task automatic rd(input logic [7:0] i);
		bus(1'b0, i, 8'h00);
	endtask
	task automatic wr_reload(input int t, input logic [15:0] r);
		wr(COUNT_LO_IDX[t], r[7:0]);
		wr(COUNT_HI_IDX[t], r[15:8]);
	endtask
	task automatic step_len(input int t, output int len);
		logic [15:0] c;
		c = cnt(t);
		len = 0;
		do begin
			@(negedge mclk);
			len++;
		end while (cnt(t) === c && len < 2000);
	endtask
	task automatic pulse(input logic [3:0] ca, input logic [3:0] cb, input logic [3:0] cm,
		input logic tr);
		@(posedge mclk);
		capture_a_hit <= ca;
		capture_b_hit <= cb;
		compare_hit <= cm;
		trip_hit <= tr;
		@(posedge mclk);
		capture_a_hit <= 4'h0;
		capture_b_hit <= 4'h0;
		compare_hit <= 4'h0;
		trip_hit <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		complete_run();
	end

	initial begin
		mclk = 0; reset_n = 0; address = '0; read = 0; write = 0; writedata = '0;
		byteenable = 4'hf; rtc_clock = 0; event_count_pin = '0; debug_break = 0;
		pwm_active = 0; compare_mode = 0; capture_a_hit = '0; capture_b_hit = '0;
		trip_hit = 0; compare_hit = '0; miscompares = 0; n_checks = 0;
		void'($urandom(32'ha4f1));
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		for (int t = 0; t < 4; t++) begin
			rd(CONTROL_IDX[t]); chk(q, {24'h0, CONTROL_RESET});
			rd(IER_IDX[t]); chk(q, {24'h0, IER_RESET});
			rd(FLAGS_IDX[t]); chk(q, {24'h0, FLAGS_RESET});
			v = $urandom;
			wr(CONTROL_IDX[t], v & 8'hfc);
			rd(CONTROL_IDX[t]); chk(q, {24'h0, v & 8'hfc});
			wr(IER_IDX[t], v);
			rd(IER_IDX[t]); chk(q, {24'h0, v & IMPL_MASK[t]});
			wr(IER_IDX[t], 8'h00);
			wr(CONTROL_IDX[t], 8'h00);
		end
		rd(8'h00); chk(q, 32'h0);
		byteenable <= 4'h0;
		wr(IER_IDX[3], 8'h7f);
		byteenable <= 4'hf;
		rd(IER_IDX[3]); chk(q, 32'h0);
		// divider ratios measured as cycles between counter steps
		for (int d = 0; d < 4; d++) begin
			wr_reload(0, 16'hffff);
			wr(CONTROL_IDX[0], 8'h07 | 8'(d << DIV_LSB));
			step_len(0, n);
			step_len(0, n);
			chk(n, period(d));
			wr(CONTROL_IDX[0], 8'h00);
		end
		// rtc, falling and rising pin edges; rtc and pin 0 toggle together, only the chosen one counts
		for (int s = 1; s < 4; s++) begin
			wr_reload(0, 16'hffff);
			wr(CONTROL_IDX[0], 8'h07 | 8'(s << SRC_LSB));
			repeat (8) @(posedge mclk);
			repeat (3) begin
				@(posedge mclk);
				rtc_clock <= 1'b1;
				event_count_pin[0] <= 1'b1;
				repeat (6) @(posedge mclk);
				rtc_clock <= 1'b0;
				event_count_pin[0] <= 1'b0;
				repeat (6) @(posedge mclk);
			end
			repeat (8) @(posedge mclk);
			chk(cnt(0), 16'hfffc);
			wr(CONTROL_IDX[0], 8'h00);
		end
		// halt on debug break, then counting through a break
		wr_reload(2, 16'hffff);
		debug_break <= 1'b1;
		wr(CONTROL_IDX[2], 8'h87);
		repeat (40) @(posedge mclk);
		chk(cnt(2), 16'hffff);
		wr(CONTROL_IDX[2], 8'h05);
		repeat (40) @(posedge mclk);
		chk(cnt(2) < 16'hffff, 1);
		debug_break <= 1'b0;
		wr(CONTROL_IDX[2], 8'h00);
		// force reload while stopped
		v = $urandom;
		wr_reload(2, {v, ~v});
		wr(CONTROL_IDX[2], 8'h00);
		@(negedge mclk);
		chk(cnt(2) === {v, ~v}, 0);
		wr(CONTROL_IDX[2], 8'h02);
		@(negedge mclk);
		chk(cnt(2), {v, ~v});
		repeat (20) @(posedge mclk);
		chk(cnt(2), {v, ~v});
		rd(CONTROL_IDX[2]); chk(q, 32'h0);
		// single pass with end-of-count interrupt and status/mask
		rd(FLAGS_IDX[0]);
		wr(IER_IDX[0], 8'h01);
		wr_reload(0, 16'h0003);
		wr(CONTROL_IDX[0], 8'h03);
		repeat (60) @(posedge mclk);
		chk(cnt(0), 16'h0);
		rd(CONTROL_IDX[0]); chk(q, 32'h0);
		chk(timer_irq[0], 1'b1);
		chk(irq, 1'b0);
		rd(IRQ_STATUS_IDX); chk(q, 32'h1);
		wr(IRQ_MASK_IDX, 8'h01);
		@(negedge mclk);
		chk(irq, 1'b1);
		wr(IRQ_STATUS_IDX, 8'h01);
		@(negedge mclk);
		chk(irq, 1'b0);
		rd(FLAGS_IDX[0]); chk(q, 32'h1);
		@(negedge mclk);
		chk(timer_irq[0], 1'b0);
		rd(FLAGS_IDX[0]); chk(q, 32'h0);
		// continuous mode never rests at zero; end of count masked by enable bit
		wr(IER_IDX[0], 8'h00);
		wr(CONTROL_IDX[0], 8'h07);
		seen = 0;
		repeat (60) begin
			@(negedge mclk);
			seen = seen | (cnt(0) === 16'h0) | timer_irq[0];
		end
		chk(seen, 1'b0);
		wr(IER_IDX[0], 8'h01);
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		chk(irq, 1'b1);
		rd(CONTROL_IDX[0]); chk(q, 32'h5);
		rd(FLAGS_IDX[0]); chk(q, 32'h1);
		wr(CONTROL_IDX[0], 8'h00);
		rd(FLAGS_IDX[0]);
		// compare, capture and trip flags of the fourth timer, then captures on all four timers
		wr(IER_IDX[3], 8'h7f);
		compare_mode <= 1'b1;
		v = $urandom;
		pulse(4'h0, 4'h0, v[3:0] | 4'h1, 1'b0);
		chk(timer_irq[3], 1'b1);
		rd(FLAGS_IDX[3]); chk(q, {25'h0, v[3:0] | 4'h1, 3'h0});
		pulse(4'h8, 4'h8, 4'hf, 1'b0);
		rd(FLAGS_IDX[3]); chk(q, 32'h7e);
		compare_mode <= 1'b0;
		pulse(4'h0, 4'h0, 4'hf, 1'b0);
		chk(timer_irq[3], 1'b0);
		rd(FLAGS_IDX[3]); chk(q, 32'h0);
		pwm_active <= 1'b1;
		compare_mode <= 1'b1;
		pulse(4'h8, 4'h8, 4'hf, 1'b1);
		rd(FLAGS_IDX[3]); chk(q, 32'h2);
		pwm_active <= 1'b0;
		compare_mode <= 1'b0;
		wr(IER_IDX[1], 8'h04);
		pulse(4'hf, 4'hf, 4'h0, 1'b1);
		chk(timer_irq, 4'ha);
		rd(FLAGS_IDX[0]); chk(q, 32'h0);
		rd(FLAGS_IDX[2]); chk(q, 32'h0);
		rd(FLAGS_IDX[1]); chk(q, 32'h6);
		rd(FLAGS_IDX[3]); chk(q, 32'h6);
		complete_run();
	end
endmodule // tb_top
